// File: inc/pm_ctl_params.svh
// Offsets, field positions, reset values and codes of the power control block
`ifndef PM_CTL_PARAMS_SVH
`define PM_CTL_PARAMS_SVH

`define PMC_ADDR_W 12
`define PMC_OFFSET 12'h014
`define PMC_WORD_LSB 2

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define BIT_KEEP_ALIVE 14
`define BIT_EE_WAKE_EN 13
`define BIT_EE_WAKE_STS 12
`define BIT_MAC_RESET 11
`define BIT_RES_CLR_STS 9
`define BIT_RES_CLR_EN 8
`define BIT_READY 7
`define FLD_SUSP_HI 6
`define FLD_SUSP_LO 5
`define FLD_CAUSE_HI 1
`define FLD_CAUSE_LO 0

`define RST_KEEP_ALIVE 1'h1
`define RST_EE_WAKE_EN 1'h0
`define RST_EE_WAKE_STS 1'h0
`define RST_MAC_RESET 1'h0
`define RST_RES_CLR_STS 1'h0
`define RST_RES_CLR_EN 1'h1
`define RST_SUSP_MODE 2'h2
`define RST_CAUSE 2'h0

`define STATE_0 2'h0
`define STATE_1 2'h1
`define STATE_2 2'h2

`define CAUSE_FRAME_BIT 1

`endif

// File: inc/pm_ctl_pkg.sv
// Types shared by the power management control block
package pm_ctl_pkg;

	typedef enum logic [0:0] {
		WR_COLLECT = 1'b0,
		WR_RESPOND = 1'b1
	} wr_phase_t;

	typedef struct packed {
		logic keep_alive;
		logic keep_alive_image;
		logic ee_wake_en;
		logic ee_wake_sts;
		logic mac_reset;
		logic res_clr_sts;
		logic res_clr_en;
		logic ready;
		logic [1:0] susp_mode;
		logic [1:0] cause;
		logic clr_wake_sts;
		logic clr_wake_en;
		logic ee_wake_qualified;
		logic crystal_stop_allowed;
		logic [1:0] eff_state;
	} ctl_t;

	typedef struct packed {
		wr_phase_t wr_phase;
		logic aw_rdy;
		logic w_rdy;
		logic aw_held;
		logic w_held;
		logic [11:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic ar_rdy;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} bus_t;

	typedef struct packed {
		ctl_t ctl;
		bus_t bus;
	} state_t;

endpackage : pm_ctl_pkg

// File: logic/mac_reset_release.sv
// Holds one MAC clock domain in reset and releases it only with its clock up
`timescale 1ns/10ps
module mac_reset_release (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic hold,
	input wire logic clk_running,
	output logic domain_reset
);

	logic reset_reg;
	logic reset_next;

	// Release waits for a running clock so the domain sees a clean edge
	always_comb begin
		reset_next = hold | ~clk_running;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reset_reg <= 1'b1;
		end else begin
			reset_reg <= reset_next;
		end
	end

	assign domain_reset = reset_reg;

endmodule : mac_reset_release

// File: logic/power_mgmt_control.sv
// Power management control register with AXI4-Lite access and resume policy
// Behaviour
// - Keep-alive bit stops crystal from ever suspending
// - Enable qualifies energy-efficient status as wake event
// - Remote resume clears enable when enables-clear set
// - Status sets on event despite write or resume clears; write one clears
// - MAC reset bit holds receive/transmit domains reset
// - Release MAC resets only with running clocks
// - Remote resume clears listed wake statuses, both registers
// - Resume also clears upper cause and energy status
// - Host resumes or bit clear leave statuses
// - Remote resume clears all wake enables by default
// - Ready low during PHY reset and loading
// - Two-bit mode selects state; resets to two
// - Entering unconfigured state forces mode to two
// - States zero and one behave identically
// - Keep-alive bit is covered by reset protection
// - Protected fields survive all but power-on reset
// - Keep-alive defaults to loaded image, else one
`timescale 1ns/10ps
`include "pm_ctl_params.svh"
module power_mgmt_control
	import pm_ctl_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic usb_reset,
	input wire logic lite_reset,
	input wire logic reset_protect,
	input wire logic config_loading,
	input wire logic config_load_done,
	input wire logic config_image_present,
	input wire logic config_keep_alive,
	input wire logic phy_reset_busy,
	input wire logic enter_unconfigured,
	input wire logic resume_done,
	input wire logic resume_remote,
	input wire logic ee_wake_event,
	input wire logic [1:0] wake_cause_event,
	input wire logic rx_clk_running,
	input wire logic tx_clk_running,
	output logic crystal_stop_allowed,
	output logic ee_wake_qualified,
	output logic [1:0] suspend_state,
	output logic clear_wake_status,
	output logic clear_wake_enables,
	output logic mac_rx_reset,
	output logic mac_tx_reset
);

	state_t state_reg;
	state_t state_next;

	// True when a byte address hits the control word
	function automatic logic hits_reg(input logic [11:0] addr);
		hits_reg = ((addr >> `PMC_WORD_LSB) ==
			(`PMC_OFFSET >> `PMC_WORD_LSB));
	endfunction : hits_reg

	// Expands byte strobes to a bit mask
	function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
		strobe_mask = {{8{strb[3]}}, {8{strb[2]}},
			{8{strb[1]}}, {8{strb[0]}}};
	endfunction : strobe_mask

	// Assembles the register image seen by a read
	function automatic logic [31:0] read_image(input ctl_t c);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[`BIT_KEEP_ALIVE] = c.keep_alive;
		v[`BIT_EE_WAKE_EN] = c.ee_wake_en;
		v[`BIT_EE_WAKE_STS] = c.ee_wake_sts;
		v[`BIT_MAC_RESET] = c.mac_reset;
		v[`BIT_RES_CLR_STS] = c.res_clr_sts;
		v[`BIT_RES_CLR_EN] = c.res_clr_en;
		v[`BIT_READY] = c.ready;
		v[`FLD_SUSP_HI:`FLD_SUSP_LO] = c.susp_mode;
		v[`FLD_CAUSE_HI:`FLD_CAUSE_LO] = c.cause;
		read_image = v;
	endfunction : read_image

	always_comb begin
		logic do_write;
		logic [31:0] wmask;
		logic [31:0] wdat;
		logic remote_resume;
		logic soft_reset;
		logic [1:0] mode;
		do_write = 1'b0;
		wmask = 32'h0000_0000;
		wdat = 32'h0000_0000;
		remote_resume = 1'b0;
		soft_reset = 1'b0;
		mode = 2'h0;
		state_next = state_reg;

		// Write address and data are taken in either order
		if (s_axi_awvalid && state_reg.bus.aw_rdy) begin
			state_next.bus.aw_held = 1'b1;
			state_next.bus.aw_addr = s_axi_awaddr;
			state_next.bus.aw_rdy = 1'b0;
		end
		if (s_axi_wvalid && state_reg.bus.w_rdy) begin
			state_next.bus.w_held = 1'b1;
			state_next.bus.w_data = s_axi_wdata;
			state_next.bus.w_strb = s_axi_wstrb;
			state_next.bus.w_rdy = 1'b0;
		end

		case (state_reg.bus.wr_phase)
			WR_COLLECT: begin
				if (state_reg.bus.aw_held && state_reg.bus.w_held) begin
					do_write = hits_reg(state_reg.bus.aw_addr);
					wmask = strobe_mask(state_reg.bus.w_strb);
					wdat = state_reg.bus.w_data & wmask;
					state_next.bus.aw_held = 1'b0;
					state_next.bus.w_held = 1'b0;
					state_next.bus.bvalid = 1'b1;
					state_next.bus.bresp = do_write ? `RESP_OKAY :
						`RESP_SLVERR;
					state_next.bus.wr_phase = WR_RESPOND;
				end
			end
			WR_RESPOND: begin
				if (s_axi_bready) begin
					state_next.bus.bvalid = 1'b0;
					state_next.bus.aw_rdy = 1'b1;
					state_next.bus.w_rdy = 1'b1;
					state_next.bus.wr_phase = WR_COLLECT;
				end
			end
			default: begin
				state_next.bus.wr_phase = WR_COLLECT;
			end
		endcase

		// One read at a time; data shows the register as it stands now
		if (s_axi_arvalid && state_reg.bus.ar_rdy) begin
			state_next.bus.ar_rdy = 1'b0;
			state_next.bus.rvalid = 1'b1;
			if (hits_reg(s_axi_araddr)) begin
				state_next.bus.rdata = read_image(state_reg.ctl);
				state_next.bus.rresp = `RESP_OKAY;
			end else begin
				state_next.bus.rdata = 32'h0000_0000;
				state_next.bus.rresp = `RESP_SLVERR;
			end
		end else if (state_reg.bus.rvalid && s_axi_rready) begin
			state_next.bus.rvalid = 1'b0;
			state_next.bus.ar_rdy = 1'b1;
		end

		// Loaded image for the keep-alive default; one without a source
		if (config_load_done) begin
			state_next.ctl.keep_alive_image = config_image_present ?
				config_keep_alive : `RST_KEEP_ALIVE;
		end

		// Plain read/write fields
		if (do_write) begin
			if (wmask[`BIT_KEEP_ALIVE]) begin
				state_next.ctl.keep_alive = wdat[`BIT_KEEP_ALIVE];
			end
			if (wmask[`BIT_EE_WAKE_EN]) begin
				state_next.ctl.ee_wake_en = wdat[`BIT_EE_WAKE_EN];
			end
			if (wmask[`BIT_MAC_RESET]) begin
				state_next.ctl.mac_reset = wdat[`BIT_MAC_RESET];
			end
			if (wmask[`BIT_RES_CLR_STS]) begin
				state_next.ctl.res_clr_sts = wdat[`BIT_RES_CLR_STS];
			end
			if (wmask[`BIT_RES_CLR_EN]) begin
				state_next.ctl.res_clr_en = wdat[`BIT_RES_CLR_EN];
			end
			if (wmask[`FLD_SUSP_LO]) begin
				state_next.ctl.susp_mode =
					wdat[`FLD_SUSP_HI:`FLD_SUSP_LO];
			end
			// Writing one clears a status bit
			if (wdat[`BIT_EE_WAKE_STS]) begin
				state_next.ctl.ee_wake_sts = 1'b0;
			end
			state_next.ctl.cause = state_reg.ctl.cause &
				~wdat[`FLD_CAUSE_HI:`FLD_CAUSE_LO];
		end

		// Resume policies act in the cycle the completion pulse arrives
		remote_resume = resume_done && resume_remote;
		state_next.ctl.clr_wake_sts = remote_resume &&
			state_reg.ctl.res_clr_sts;
		state_next.ctl.clr_wake_en = remote_resume &&
			state_reg.ctl.res_clr_en;
		if (remote_resume && state_reg.ctl.res_clr_sts) begin
			state_next.ctl.ee_wake_sts = 1'b0;
			state_next.ctl.cause[`CAUSE_FRAME_BIT] = 1'b0;
		end
		if (remote_resume && state_reg.ctl.res_clr_en) begin
			state_next.ctl.ee_wake_en = 1'b0;
		end

		// Hardware sets come after the write and resume clears so those never lose an event
		if (ee_wake_event) begin
			state_next.ctl.ee_wake_sts = 1'b1;
		end
		state_next.ctl.cause = state_next.ctl.cause | wake_cause_event;

		if (enter_unconfigured) begin
			state_next.ctl.susp_mode = `RST_SUSP_MODE;
		end

		// USB and lite resets restore defaults; protection spares keep-alive
		soft_reset = usb_reset || lite_reset;
		if (soft_reset) begin
			if (!reset_protect) begin
				state_next.ctl.keep_alive =
					state_reg.ctl.keep_alive_image;
			end
			state_next.ctl.ee_wake_en = `RST_EE_WAKE_EN;
			state_next.ctl.ee_wake_sts = `RST_EE_WAKE_STS;
			state_next.ctl.mac_reset = `RST_MAC_RESET;
			state_next.ctl.res_clr_sts = `RST_RES_CLR_STS;
			state_next.ctl.res_clr_en = `RST_RES_CLR_EN;
			state_next.ctl.susp_mode = `RST_SUSP_MODE;
			state_next.ctl.cause = `RST_CAUSE;
		end

		state_next.ctl.ready = !phy_reset_busy && !config_loading;

		// Outputs follow the stored fields one cycle later
		state_next.ctl.crystal_stop_allowed =
			!state_reg.ctl.keep_alive;
		state_next.ctl.ee_wake_qualified = state_reg.ctl.ee_wake_en &&
			state_reg.ctl.ee_wake_sts;
		mode = state_reg.ctl.susp_mode;
		// The second shallow code collapses onto the first state
		state_next.ctl.eff_state = (mode == `STATE_1) ? `STATE_0 : mode;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg.ctl.keep_alive <= `RST_KEEP_ALIVE;
			state_reg.ctl.keep_alive_image <= `RST_KEEP_ALIVE;
			state_reg.ctl.ee_wake_en <= `RST_EE_WAKE_EN;
			state_reg.ctl.ee_wake_sts <= `RST_EE_WAKE_STS;
			state_reg.ctl.mac_reset <= `RST_MAC_RESET;
			state_reg.ctl.res_clr_sts <= `RST_RES_CLR_STS;
			state_reg.ctl.res_clr_en <= `RST_RES_CLR_EN;
			state_reg.ctl.ready <= 1'b0;
			state_reg.ctl.susp_mode <= `RST_SUSP_MODE;
			state_reg.ctl.cause <= `RST_CAUSE;
			state_reg.ctl.clr_wake_sts <= 1'b0;
			state_reg.ctl.clr_wake_en <= 1'b0;
			state_reg.ctl.ee_wake_qualified <= 1'b0;
			state_reg.ctl.crystal_stop_allowed <= 1'b0;
			state_reg.ctl.eff_state <= `STATE_2;
			state_reg.bus.wr_phase <= WR_COLLECT;
			state_reg.bus.aw_rdy <= 1'b1;
			state_reg.bus.w_rdy <= 1'b1;
			state_reg.bus.aw_held <= 1'b0;
			state_reg.bus.w_held <= 1'b0;
			state_reg.bus.aw_addr <= 12'h000;
			state_reg.bus.w_data <= 32'h0000_0000;
			state_reg.bus.w_strb <= 4'h0;
			state_reg.bus.bvalid <= 1'b0;
			state_reg.bus.bresp <= `RESP_OKAY;
			state_reg.bus.ar_rdy <= 1'b1;
			state_reg.bus.rvalid <= 1'b0;
			state_reg.bus.rdata <= 32'h0000_0000;
			state_reg.bus.rresp <= `RESP_OKAY;
		end else begin
			state_reg <= state_next;
		end
	end

	mac_reset_release rx_release (
		.aclk(aclk),
		.aresetn(aresetn),
		.hold(state_reg.ctl.mac_reset),
		.clk_running(rx_clk_running),
		.domain_reset(mac_rx_reset)
	);

	mac_reset_release tx_release (
		.aclk(aclk),
		.aresetn(aresetn),
		.hold(state_reg.ctl.mac_reset),
		.clk_running(tx_clk_running),
		.domain_reset(mac_tx_reset)
	);

	assign s_axi_awready = state_reg.bus.aw_rdy;
	assign s_axi_wready = state_reg.bus.w_rdy;
	assign s_axi_bvalid = state_reg.bus.bvalid;
	assign s_axi_bresp = state_reg.bus.bresp;
	assign s_axi_arready = state_reg.bus.ar_rdy;
	assign s_axi_rvalid = state_reg.bus.rvalid;
	assign s_axi_rdata = state_reg.bus.rdata;
	assign s_axi_rresp = state_reg.bus.rresp;
	assign crystal_stop_allowed = state_reg.ctl.crystal_stop_allowed;
	assign ee_wake_qualified = state_reg.ctl.ee_wake_qualified;
	assign suspend_state = state_reg.ctl.eff_state;
	assign clear_wake_status = state_reg.ctl.clr_wake_sts;
	assign clear_wake_enables = state_reg.ctl.clr_wake_en;

endmodule : power_mgmt_control

// File: tb/power_mgmt_control_props.sv
// Concurrent checks on the ports of the power management control block
`timescale 1ns/10ps
module power_mgmt_control_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic enter_unconfigured,
	input wire logic resume_done,
	input wire logic resume_remote,
	input wire logic rx_clk_running,
	input wire logic tx_clk_running,
	input wire logic [1:0] suspend_state,
	input wire logic clear_wake_status,
	input wire logic clear_wake_enables,
	input wire logic mac_rx_reset,
	input wire logic mac_tx_reset
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence host_resume;
		resume_done && !resume_remote;
	endsequence
	// A write landing on the same edge may legally move the mode
	sequence unconf_alone;
		enter_unconfigured && !s_axi_awvalid && !s_axi_wvalid;
	endsequence

	// Held address and data are merged one edge after both are taken
	chk_write_answer: assert property (wr_taken |=> ##1 s_axi_bvalid)
		else $error("write response not given two cycles on");
	chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid)
		else $error("read data not given next cycle");
	chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	chk_rx_clock_gate: assert property (
		!rx_clk_running |=> mac_rx_reset)
		else $error("receive reset released without clock");
	chk_tx_clock_gate: assert property (
		!tx_clk_running |=> mac_tx_reset)
		else $error("transmit reset released without clock");
	chk_state_merge: assert property (suspend_state != 2'h1)
		else $error("state one not merged with state zero");
	chk_unconf_mode: assert property (
		unconf_alone |=> ##1 suspend_state == 2'h2)
		else $error("unconfigured entry did not force state two");
	chk_host_resume: assert property (
		host_resume |=> !clear_wake_status && !clear_wake_enables)
		else $error("host resume cleared wake flags");
	chk_clear_cause: assert property (
		clear_wake_status || clear_wake_enables
		|-> $past(resume_done) && $past(resume_remote))
		else $error("wake clear pulse without remote resume");
endmodule : power_mgmt_control_props

bind power_mgmt_control power_mgmt_control_props chk (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.enter_unconfigured, .resume_done, .resume_remote, .rx_clk_running,
	.tx_clk_running, .suspend_state, .clear_wake_status,
	.clear_wake_enables, .mac_rx_reset, .mac_tx_reset);

// File: tb/tb_power_mgmt_control.sv
// Self-checking bench for the power management control block
`timescale 1ns/10ps
`include "pm_ctl_params.svh"
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
$display("MISMATCH %s exp %h got %h", n, e, a); end end
`define SETTLE repeat (3) @(posedge aclk);
`define PULSE(s) s <= 1'h1; @(posedge aclk); s <= 1'h0;
module tb_power_mgmt_control;
	localparam logic [11:0] A = `PMC_OFFSET;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp, suspend_state, wake_cause_event = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, usb_reset = 0, lite_reset = 0, reset_protect = 0;
	logic config_loading = 0, config_load_done = 0, config_image_present = 0;
	logic config_keep_alive = 0, phy_reset_busy = 1, enter_unconfigured = 0;
	logic resume_done = 0, resume_remote = 0, ee_wake_event = 0;
	logic rx_clk_running = 1, tx_clk_running = 1, crystal_stop_allowed;
	logic ee_wake_qualified, clear_wake_status, clear_wake_enables;
	logic mac_rx_reset, mac_tx_reset;
	int bad_count = 0, n_tests = 0, cyc = 0, n_cs = 0, n_ce = 0;

	always #2.5 aclk = ~aclk;

	power_mgmt_control uut (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .usb_reset, .lite_reset, .reset_protect,
		.config_loading, .config_load_done, .config_image_present,
		.config_keep_alive, .phy_reset_busy, .enter_unconfigured, .resume_done,
		.resume_remote, .ee_wake_event, .wake_cause_event, .rx_clk_running,
		.tx_clk_running, .crystal_stop_allowed, .ee_wake_qualified,
		.suspend_state, .clear_wake_status, .clear_wake_enables, .mac_rx_reset,
		.mac_tx_reset);

	task complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run

	// Counting pulses also catches a pulse that lasts too long
	always @(posedge aclk) begin
		cyc++;
		if (clear_wake_status) n_cs++;
		if (clear_wake_enables) n_ce++;
		if (cyc == 4000) begin
			bad_count++;
			complete_run;
		end
	end

	task automatic wr(input logic [11:0] a, input logic [31:0] d,
			input logic [1:0] r = `RESP_OKAY);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) begin
				s_axi_bready <= 1'h0;
				`CHK("bresp", r, s_axi_bresp)
			end
		end while (s_axi_bready);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] e,
			input logic [1:0] r = `RESP_OKAY);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) begin
				s_axi_rready <= 1'h0;
				`CHK("rdata", e, s_axi_rdata)
				`CHK("rresp", r, s_axi_rresp)
			end
		end while (s_axi_rready);
	endtask : rd

	task t_reset;
		rd(A, 32'h0000_4140);
		`CHK("mode", 2'h2, suspend_state)
		`CHK("xtal", 1'h0, crystal_stop_allowed)
		phy_reset_busy <= 1'h0;
		`SETTLE
		rd(A, 32'h0000_41C0);
		config_loading <= 1'h1;
		`SETTLE
		rd(A, 32'h0000_4140);
		config_loading <= 1'h0;
		rd(12'h018, 32'h0, `RESP_SLVERR);
		wr(12'h000, 32'hFFFF_FFFF, `RESP_SLVERR);
		rd(A, 32'h0000_41C0);
	endtask : t_reset

	task t_modes;
		for (int m = 0; m < 4; m++) begin
			wr(A, 32'h0000_0100 | (m << 5));
			rd(A, 32'h0000_0180 | (m << 5));
			`CHK("state", (m == 1) ? 2'h0 : 2'(m), suspend_state)
		end
		`CHK("xtal", 1'h1, crystal_stop_allowed)
		`PULSE(enter_unconfigured)
		`SETTLE
		`CHK("state", 2'h2, suspend_state)
		rd(A, 32'h0000_01C0);
	endtask : t_modes

	task t_mac;
		`CHK("rx", 1'h0, mac_rx_reset)
		wr(A, 32'h0000_0940);
		`SETTLE
		`CHK("rx", 1'h1, mac_rx_reset)
		`CHK("tx", 1'h1, mac_tx_reset)
		rx_clk_running <= 1'h0;
		wr(A, 32'h0000_0140);
		`SETTLE
		`CHK("rx", 1'h1, mac_rx_reset)
		`CHK("tx", 1'h0, mac_tx_reset)
		rx_clk_running <= 1'h1;
		tx_clk_running <= 1'h0;
		`SETTLE
		`CHK("rx", 1'h0, mac_rx_reset)
		`CHK("tx", 1'h1, mac_tx_reset)
		tx_clk_running <= 1'h1;
	endtask : t_mac

	task automatic resume(input logic remote);
		resume_done <= 1'h1;
		resume_remote <= remote;
		@(posedge aclk);
		resume_done <= 1'h0;
		`SETTLE
	endtask : resume

	task t_wake;
		wake_cause_event <= 2'h3;
		`PULSE(ee_wake_event)
		wake_cause_event <= 2'h0;
		rd(A, 32'h0000_11C3);
		`CHK("qual", 1'h0, ee_wake_qualified)
		wr(A, 32'h0000_2340);
		rd(A, 32'h0000_33C3);
		`CHK("qual", 1'h1, ee_wake_qualified)
		resume(1'h0);
		rd(A, 32'h0000_33C3);
		`CHK("sts_pulse", 0, n_cs)
		resume(1'h1);
		rd(A, 32'h0000_03C1);
		`CHK("sts_pulse", 1, n_cs)
		`CHK("en_pulse", 1, n_ce)
		wr(A, 32'h0000_0341);
		rd(A, 32'h0000_03C0);
		`PULSE(ee_wake_event)
		rd(A, 32'h0000_13C0);
		wr(A, 32'h0000_3040);
		rd(A, 32'h0000_20C0);
		resume(1'h1);
		rd(A, 32'h0000_20C0);
		`CHK("sts_pulse", 1, n_cs)
	endtask : t_wake

	task t_resets;
		wr(A, 32'h0000_0040);
		reset_protect <= 1'h1;
		`PULSE(usb_reset)
		rd(A, 32'h0000_01C0);
		`CHK("xtal", 1'h1, crystal_stop_allowed)
		reset_protect <= 1'h0;
		`PULSE(lite_reset)
		rd(A, 32'h0000_41C0);
		`CHK("xtal", 1'h0, crystal_stop_allowed)
		config_image_present <= 1'h1;
		`PULSE(config_load_done)
		`PULSE(usb_reset)
		rd(A, 32'h0000_01C0);
		reset_protect <= 1'h1;
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		`SETTLE
		rd(A, 32'h0000_41C0);
	endtask : t_resets

	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		t_reset;
		t_modes;
		t_mac;
		t_wake;
		t_resets;
		complete_run;
	end
endmodule : tb_power_mgmt_control
